// file: hdl/ucte_top.sv
// Up-counter timer with compare, auto capture and APB registers
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ucte_top #(
  parameter int CNT_W = 16,
  parameter int DIV_W = 13,
  parameter int SLOW_LOG2 = 12
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_INPUT_PIN,
  output logic TIMER_MATCH_IRQ
);
  // Control register and its fields
  logic [ucte_pkg::CTL_W-1:0] timer_control_reg;
  logic [1:0] operating_mode_sel;
  logic [1:0] source_clock_sel;
  logic [1:0] run_control;
  logic auto_capture_en; // Shares its bit with trigger_stop_sel
  logic trigger_stop_sel;
  logic prescaler_tap_sel;
  logic low_speed_mode; // Covers the low speed sleep mode too

  // Counting state
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] compare_a_reg;
  logic [CNT_W-1:0] capture_b_reg;
  logic [CNT_W-1:0] compare_buf; // Written bytes awaiting load
  logic compare_pending; // Upper byte written, load at next tick
  ucte_pkg::ucte_state_type state;

  // Pin and tick signals
  logic src_tick; // Internal source clock tick
  logic pin_level; // Filtered pin
  logic pin_prev;
  logic rise_edge;
  logic fall_edge;
  logic count_edge; // Selected edge of the pin
  logic opp_edge; // Edge opposite to the selected one

  // Mode decode
  logic mode_ok;
  logic event_mode;
  logic timer_mode;
  logic trig_mode;
  logic match;
  logic step; // Count step for the active mode
  logic load_tick; // Source clock edge used for compare load

  // Bus decode
  logic access;
  logic wr;
  logic addr_ok;

  assign operating_mode_sel = timer_control_reg[ucte_pkg::CTL_MODE_LSB +: 2];
  assign source_clock_sel = timer_control_reg[ucte_pkg::CTL_CLK_LSB +: 2];
  assign run_control = timer_control_reg[ucte_pkg::CTL_RUN_LSB +: 2];
  assign auto_capture_en = timer_control_reg[ucte_pkg::CTL_CAP_BIT];
  assign trigger_stop_sel = timer_control_reg[ucte_pkg::CTL_CAP_BIT];
  assign prescaler_tap_sel = timer_control_reg[ucte_pkg::CTL_TAP_BIT];
  assign low_speed_mode = timer_control_reg[ucte_pkg::CTL_SLOW_BIT];

  // Prescaler for the three internal taps
  ucte_prescaler #(
    .DIV_W(DIV_W),
    .SLOW_LOG2(SLOW_LOG2)
  ) u_prescaler (
    .clock(CLOCK),
    .resetn(RESETN),
    .clk_sel(source_clock_sel),
    .tap_sel(prescaler_tap_sel),
    .tick(src_tick)
  );

  // Pin synchroniser and noise filter
  ucte_pin_filter u_filter (
    .clock(CLOCK),
    .resetn(RESETN),
    .pin(TIMER_INPUT_PIN),
    .bypass(low_speed_mode),
    .level(pin_level)
  );

  // Edge detection on the filtered level
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_level;
    end
  end

  // Mode and edge decode
  always_comb begin
    rise_edge = pin_level && !pin_prev;
    fall_edge = !pin_level && pin_prev;
    count_edge = (run_control == ucte_pkg::RUN_FALL) ? fall_edge : rise_edge;
    opp_edge = (run_control == ucte_pkg::RUN_FALL) ? rise_edge : fall_edge;
    mode_ok = operating_mode_sel == ucte_pkg::MODE_BASIC;
    event_mode = mode_ok && source_clock_sel == ucte_pkg::CLK_PIN &&
      run_control[1];
    timer_mode = mode_ok && source_clock_sel != ucte_pkg::CLK_PIN &&
      run_control == ucte_pkg::RUN_CMD;
    trig_mode = mode_ok && source_clock_sel != ucte_pkg::CLK_PIN && run_control[1];
    match = counter == compare_a_reg;
    step = event_mode ? count_edge : src_tick;
    load_tick = (source_clock_sel == ucte_pkg::CLK_PIN) ? count_edge : src_tick;
  end

  // Run state: stop, waiting for a trigger, or counting
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state <= ucte_pkg::ST_STOP;
    end else if (timer_mode || event_mode) begin
      state <= ucte_pkg::ST_RUN;
    end else if (!trig_mode) begin
      state <= ucte_pkg::ST_STOP;
    end else begin
      case (state)
        ucte_pkg::ST_RUN: begin
          // Match wins over a stop edge in the same cycle
          if (src_tick && match) begin
            state <= ucte_pkg::ST_WAIT_TRIG;
          end else if (trigger_stop_sel && opp_edge) begin
            state <= ucte_pkg::ST_WAIT_TRIG;
          end
        end
        ucte_pkg::ST_WAIT_TRIG: begin
          if (count_edge) begin
            state <= ucte_pkg::ST_RUN;
          end
        end
        default: begin
          state <= ucte_pkg::ST_WAIT_TRIG;
        end
      endcase
    end
  end

  // Up-counter
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      counter <= ucte_pkg::COUNT_ZERO;
    end else if (!(timer_mode || event_mode || trig_mode)) begin
      counter <= ucte_pkg::COUNT_ZERO;
    end else if (event_mode) begin
      // Match is judged on the opposite edge, so it sees a settled count
      if (opp_edge && match) begin
        counter <= ucte_pkg::COUNT_ZERO;
      end else if (count_edge) begin
        counter <= counter + ucte_pkg::COUNT_ONE;
      end
    end else if (state != ucte_pkg::ST_RUN) begin
      counter <= ucte_pkg::COUNT_ZERO;
    end else if (trig_mode && trigger_stop_sel && opp_edge && !(src_tick && match)) begin
      counter <= ucte_pkg::COUNT_ZERO;
    end else if (src_tick) begin
      if (match) begin
        counter <= ucte_pkg::COUNT_ZERO;
      end else begin
        counter <= counter + ucte_pkg::COUNT_ONE;
      end
    end
  end

  // Match pulse; repeated trigger edges never reach here
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      TIMER_MATCH_IRQ <= 1'b0;
    end else if (event_mode) begin
      TIMER_MATCH_IRQ <= opp_edge && match;
    end else begin
      TIMER_MATCH_IRQ <= (timer_mode || trig_mode) && state == ucte_pkg::ST_RUN &&
        src_tick && match;
    end
  end

  // Auto capture; readers must allow one tick after enabling
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      capture_b_reg <= ucte_pkg::COUNT_ZERO;
    end else if (auto_capture_en && (timer_mode || event_mode) && step) begin
      capture_b_reg <= counter;
    end
  end

  // Compare buffer; the upper byte arms the load
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      compare_buf <= ucte_pkg::COUNT_ZERO;
      compare_pending <= 1'b0;
    end else if (wr && PADDR == ucte_pkg::OFS_COMPARE) begin
      if (PSTRB[0]) begin
        compare_buf[7:0] <= PWDATA[7:0];
      end
      if (PSTRB[1]) begin
        compare_buf[15:8] <= PWDATA[15:8];
        compare_pending <= 1'b1;
      end
    end else if (load_tick) begin
      compare_pending <= 1'b0;
    end
  end

  // Active compare value changes only on a source clock edge
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      compare_a_reg <= ucte_pkg::COUNT_ZERO;
    end else if (compare_pending && load_tick) begin
      compare_a_reg <= compare_buf;
    end
  end

  // Bus decode; one wait state gives registered answers
  always_comb begin
    access = PSEL && PENABLE && !PREADY;
    wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    case (PADDR)
      ucte_pkg::OFS_CTRL, ucte_pkg::OFS_COMPARE: addr_ok = 1'b1;
      ucte_pkg::OFS_CAPTURE, ucte_pkg::OFS_COUNT: addr_ok = !PWRITE;
      ucte_pkg::OFS_STATUS: addr_ok = !PWRITE;
      default: addr_ok = 1'b0;
    endcase
  end

  // Control register write with byte strobes
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      timer_control_reg <= ucte_pkg::CTL_RESET;
    end else if (wr && PADDR == ucte_pkg::OFS_CTRL) begin
      if (PSTRB[0]) begin
        timer_control_reg[7:0] <= PWDATA[7:0];
      end
      if (PSTRB[1]) begin
        timer_control_reg[9:8] <= PWDATA[9:8];
      end
    end
  end

  // Answer: ready, error and read data all from flops
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= access;
      PSLVERR <= access && !addr_ok;
      PRDATA <= 32'h0000_0000;
      if (access && !PWRITE) begin
        case (PADDR)
          ucte_pkg::OFS_CTRL: PRDATA <= {22'h00_0000, timer_control_reg};
          ucte_pkg::OFS_COMPARE: PRDATA <= {16'h0000, compare_a_reg};
          ucte_pkg::OFS_CAPTURE: PRDATA <= {16'h0000, capture_b_reg};
          ucte_pkg::OFS_COUNT: PRDATA <= {16'h0000, counter};
          ucte_pkg::OFS_STATUS: PRDATA <= {28'h000_0000, compare_pending,
            pin_level, state == ucte_pkg::ST_WAIT_TRIG, state == ucte_pkg::ST_RUN};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  timer_count_a: assert property (timer_mode && src_tick && !match &&
    state == ucte_pkg::ST_RUN && $stable(timer_control_reg) |=>
    counter == $past(counter) + ucte_pkg::COUNT_ONE) else $error("timer missed a tick");
  timer_match_a: assert property (timer_mode && state == ucte_pkg::ST_RUN &&
    src_tick && match |=> TIMER_MATCH_IRQ && counter == ucte_pkg::COUNT_ZERO)
    else $error("timer match not handled");
  capture_copy_a: assert property (auto_capture_en && (timer_mode || event_mode) &&
    step |=> capture_b_reg == $past(counter)) else $error("capture missed");
  trig_start_a: assert property (trig_mode && state == ucte_pkg::ST_WAIT_TRIG &&
    count_edge |=> state == ucte_pkg::ST_RUN)
    else $error("trigger did not start");
  trig_match_a: assert property (trig_mode && state == ucte_pkg::ST_RUN && src_tick &&
    match ##1 trig_mode |-> state == ucte_pkg::ST_WAIT_TRIG && TIMER_MATCH_IRQ &&
    counter == ucte_pkg::COUNT_ZERO) else $error("trigger match not halted");
  stop_edge_a: assert property (trig_mode && trigger_stop_sel && opp_edge &&
    state == ucte_pkg::ST_RUN && !(src_tick && match) ##1 trig_mode |->
    !TIMER_MATCH_IRQ && counter == ucte_pkg::COUNT_ZERO) else $error("stop edge wrong");
  retrig_ignore_a: assert property (trig_mode && !trigger_stop_sel &&
    state == ucte_pkg::ST_RUN && (count_edge || opp_edge) && !src_tick ##1 trig_mode |->
    $stable(counter) && state == ucte_pkg::ST_RUN) else $error("edge disturbed count");
  event_count_a: assert property (event_mode && count_edge ##1 event_mode |->
    counter == $past(counter) + ucte_pkg::COUNT_ONE) else $error("event not counted");
  event_match_a: assert property (event_mode && opp_edge && match |=>
    TIMER_MATCH_IRQ && (counter == ucte_pkg::COUNT_ZERO || !event_mode))
    else $error("event match missed");
  stop_clear_a: assert property (run_control == ucte_pkg::RUN_STOP |=>
    counter == ucte_pkg::COUNT_ZERO) else $error("stop did not clear");
  compare_load_a: assert property (compare_pending && load_tick &&
    !(wr && PADDR == ucte_pkg::OFS_COMPARE) |=> compare_a_reg == $past(compare_buf) &&
    !compare_pending) else $error("compare load wrong");
  low_only_a: assert property (wr && PADDR == ucte_pkg::OFS_COMPARE &&
    PSTRB[1:0] == 2'h1 && !compare_pending |=> !compare_pending)
    else $error("lower byte armed load");
  // Match pulses are single cycles; ticks and pin edges are spaced apart
  irq_pulse_a: assert property (TIMER_MATCH_IRQ |=> !TIMER_MATCH_IRQ)
    else $error("match pulse too long");
  // A stopped or foreign mode never signals a match
  stopped_quiet_a: assert property (!(timer_mode || event_mode || trig_mode) |=>
    !TIMER_MATCH_IRQ) else $error("match while stopped");

  // Main scenarios the bench should reach
  timer_wrap_c: cover property (timer_mode && TIMER_MATCH_IRQ);
  stop_edge_c: cover property (trig_mode && trigger_stop_sel && opp_edge &&
    state == ucte_pkg::ST_RUN);
  trig_halt_c: cover property (trig_mode && state == ucte_pkg::ST_RUN ##1
    state == ucte_pkg::ST_WAIT_TRIG);
  event_match_c: cover property (event_mode && TIMER_MATCH_IRQ);
  capture_c: cover property (auto_capture_en && timer_mode && step);
endmodule

// file: hdl/ucte_pkg.sv
// Shared constants for the up-counter timer with event capture
package ucte_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_CAPTURE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Control register field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_CLK_LSB = 2;
  localparam int CTL_RUN_LSB = 4;
  localparam int CTL_CAP_BIT = 6;
  localparam int CTL_TAP_BIT = 8;
  localparam int CTL_SLOW_BIT = 9;
  localparam int CTL_W = 10;
  localparam logic [9:0] CTL_RESET = 10'h000;
  // Run control codes
  localparam logic [1:0] RUN_STOP = 2'h0;
  localparam logic [1:0] RUN_CMD = 2'h1;
  localparam logic [1:0] RUN_RISE = 2'h2;
  localparam logic [1:0] RUN_FALL = 2'h3;
  // Source clock codes, code 3 is the input pin
  localparam logic [1:0] CLK_PIN = 2'h3;
  // Operating mode code for timer, trigger timer and event counter
  localparam logic [1:0] MODE_BASIC = 2'h0;
  // Prescaler divide exponents for codes 0, 1 and 2
  localparam int PRE_LOG2_C0 = 11;
  localparam int PRE_LOG2_C1 = 7;
  localparam int PRE_LOG2_C2 = 3;
  // Noise filter: pulses up to this many fc cycles are dropped
  localparam int FILTER_REJECT_FC = 4;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // Counter states
  typedef enum logic [1:0] {ST_STOP, ST_WAIT_TRIG, ST_RUN} ucte_state_type;
endpackage

// file: hdl/ucte_prescaler.sv
// Free running prescaler that yields the internal source clock tick
`timescale 1ns/1ps
module ucte_prescaler #(
  parameter int DIV_W = 13,
  parameter int SLOW_LOG2 = 12
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] clk_sel,
  input wire logic tap_sel,
  output logic tick
);
  logic [DIV_W-1:0] divider; // Divider chain
  logic [DIV_W-1:0] mask; // Low bits that must all be one
  int exponent;

  // Exponent of the selected tap; the slow tap replaces code 0
  always_comb begin
    case (clk_sel)
      2'h0: exponent = tap_sel ? SLOW_LOG2 : ucte_pkg::PRE_LOG2_C0;
      2'h1: exponent = ucte_pkg::PRE_LOG2_C1;
      default: exponent = ucte_pkg::PRE_LOG2_C2;
    endcase
    mask = {DIV_W{1'b1}} >> (DIV_W - exponent);
  end

  // Divider runs always so a tap change never stalls it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      divider <= '0;
    end else begin
      divider <= divider + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // One clock tick each time the selected tap wraps
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tick <= 1'b0;
    end else begin
      tick <= (divider & mask) == mask;
    end
  end
endmodule

// file: hdl/ucte_pin_filter.sv
// Synchroniser and noise filter for the timer input pin
`timescale 1ns/1ps
module ucte_pin_filter #(
  parameter int REJECT = ucte_pkg::FILTER_REJECT_FC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin,
  input wire logic bypass,
  output logic level
);
  logic sync1; // First stage, read only by sync2
  logic sync2; // Safe copy of the pin
  logic [3:0] run_len; // Cycles the input has differed from level

  // Two stage synchroniser
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // Level follows only after REJECT+1 stable cycles; slow mode skips it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      level <= 1'b0;
      run_len <= 4'h0;
    end else if (bypass) begin
      level <= sync2;
      run_len <= 4'h0;
    end else if (sync2 == level) begin
      run_len <= 4'h0;
    end else if (run_len == 4'(REJECT)) begin
      level <= sync2;
      run_len <= 4'h0;
    end else begin
      run_len <= run_len + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Judge the filter only where the edge before was not in bypass
  noise_reject_a: assert property (!$past(bypass) && $changed(level) |->
    $past(run_len) == 4'(REJECT)) else $error("filter passed a short pulse");
  filter_bypass_a: assert property (bypass |=>
    level == $past(sync2)) else $error("bypass did not follow pin");
endmodule

// file: test/ucte_pulse_src.sv
// Model of the pulse source that drives the timer input pin
`timescale 1ns/1ps
module ucte_pulse_src (
  input wire logic clock,
  output logic pin
);
  // Pin rests low; it has no pull, so the model always drives a level
  initial begin
    pin = 1'h0;
  end
  // Drives n pulses of hi cycles high and lo cycles low, just after rising edges
  // Phases of 5 cycles or more are needed to pass the filter; a width of 3 is used only to probe the filter
  task automatic burst(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      pin <= 1'h1;
      repeat (hi) @(posedge clock);
      // No low phase leaves the pin high for the caller
      if (lo > 0) begin
        pin <= 1'h0;
        repeat (lo) @(posedge clock);
      end
    end
  endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the up-counter timer over APB and the input pin
`timescale 1ns/1ps
module tb;
  logic CLOCK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic TIMER_INPUT_PIN, TIMER_MATCH_IRQ;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdv;
  logic [3:0] PSTRB;
  // Expected answer: data, mask, error flag
  logic [64:0] exp_q[$];
  logic [64:0] ent;
  int err_count, n_compared, cyc, irq_n, irq_last, irq_prev, i0, nval;
  integer seed;
  ucte_top ucte_top_inst (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_INPUT_PIN(TIMER_INPUT_PIN),
    .TIMER_MATCH_IRQ(TIMER_MATCH_IRQ));
  ucte_pulse_src ucte_pulse_src_inst (.clock(CLOCK), .pin(TIMER_INPUT_PIN));
  // Clock at 5 ns
  initial begin
    CLOCK = 1'h0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  // Count a mismatch and print both values
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One APB transfer; the expectation is queued for the answer watcher
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [31:0] e, input logic [31:0] m, input logic er);
    exp_q.push_back({e, m, er});
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    // Hold the request until ready is sampled high; no latency is assumed
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'h1);
    rdv = PRDATA;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    // One idle edge so the next setup never reassigns PSEL in this step
    @(posedge CLOCK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'h1, a, d, s, 32'h0, 32'h0, 1'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'h0, a, 32'h0, 4'h0, e, m, 1'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic burst(input int n, input int hi, input int lo);
    ucte_pulse_src_inst.burst(n, hi, lo);
  endtask
  // Bounded wait for a match pulse
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (TIMER_MATCH_IRQ !== 1'h1 && n < 2000);
    check(32'(n < 2000), 32'h1);
  endtask
  // Answer watcher: each ready pulse takes the oldest expectation
  always @(posedge CLOCK) begin
    if (PREADY === 1'h1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        ent = exp_q.pop_front();
        check(PRDATA & ent[32:1], ent[64:33] & ent[32:1]);
        check(32'(PSLVERR), 32'(ent[0]));
      end
    end
  end
  // Cycle count and a log of match pulses
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (TIMER_MATCH_IRQ === 1'h1) begin
      irq_n <= irq_n + 1;
      irq_prev <= irq_last;
      irq_last <= cyc;
    end
  end
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge CLOCK);
    err_count++;
    test_done();
  end
  initial begin
    RESETN = 1'h0;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 8'h0;
    PWDATA = 32'h0;
    PSTRB = 4'h0;
    seed = 32'hc18293d9;
    repeat (6) @(posedge CLOCK);
    RESETN <= 1'h1;
    @(posedge CLOCK);
    // Reset values and refused accesses
    rd(ucte_pkg::OFS_CTRL, 32'h0, 32'h3ff);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    apb(1'h0, 8'h14, 32'h0, 4'h0, 32'h0, 32'hffffffff, 1'h1);
    apb(1'h1, ucte_pkg::OFS_COUNT, 32'h5, 4'hf, 32'h0, 32'hffffffff, 1'h1);
    test_end("regs");
    // Timer with a random compare value, tick every 8 cycles
    nval = 2 + ({$random(seed)} % 8);
    wr(ucte_pkg::OFS_CTRL, 32'h08, 4'h3);
    wr(ucte_pkg::OFS_COMPARE, 32'(nval), 4'h3);
    idle(20);
    rd(ucte_pkg::OFS_COMPARE, 32'(nval), 32'hffff);
    wr(ucte_pkg::OFS_CTRL, 32'h18, 4'h3);
    idle(30 * (nval + 1));
    check(32'(irq_last - irq_prev), 32'(8 * (nval + 1)));
    wr(ucte_pkg::OFS_CTRL, 32'h58, 4'h3);
    idle(20);
    wait_irq();
    // Captured value is the pre-clear or the cleared count
    rd(ucte_pkg::OFS_CAPTURE, 32'h0, 32'h0);
    check(32'(rdv == 0 || rdv == nval), 32'h1);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    wr(ucte_pkg::OFS_COMPARE, 32'h1234, 4'h1);
    idle(20);
    rd(ucte_pkg::OFS_COMPARE, 32'(nval), 32'hffff);
    wr(ucte_pkg::OFS_COMPARE, 32'h1234, 4'h2);
    idle(20);
    rd(ucte_pkg::OFS_COMPARE, 32'h1234, 32'hffff);
    wr(ucte_pkg::OFS_CTRL, 32'h08, 4'h3);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    wr(ucte_pkg::OFS_CTRL, 32'h19, 4'h3);
    idle(100);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    wr(ucte_pkg::OFS_CTRL, 32'h08, 4'h3);
    test_end("timer");
    // Trigger timer, match after 21 ticks
    wr(ucte_pkg::OFS_COMPARE, 32'h14, 4'h3);
    idle(20);
    wr(ucte_pkg::OFS_CTRL, 32'h68, 4'h3);
    idle(50);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    i0 = irq_n;
    burst(1, 60, 40);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    burst(1, 300, 40);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    check(32'(irq_n - i0), 32'h1);
    wr(ucte_pkg::OFS_CTRL, 32'h08, 4'h3);
    wr(ucte_pkg::OFS_CTRL, 32'h28, 4'h3);
    i0 = irq_n;
    // A restart on the second rise would push the match past this point
    burst(2, 40, 40);
    idle(60);
    check(32'(irq_n - i0), 32'h1);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    wr(ucte_pkg::OFS_CTRL, 32'h08, 4'h3);
    test_end("trigger");
    // Event counting on rising, then falling edges, compare 4
    for (int r = 2; r < 4; r++) begin
      wr(ucte_pkg::OFS_COMPARE, 32'h4, 4'h3);
      idle(20);
      wr(ucte_pkg::OFS_CTRL, 32'h4c | (r << 4), 4'h3);
      i0 = irq_n;
      burst(3, 20, 20);
      burst(1, 20, 0);
      // Count equals compare while the pin is still high
      if (r == 2) begin
        rd(ucte_pkg::OFS_COUNT, 32'h4, 32'hffff);
        check(32'(irq_n - i0), 32'h0);
      end
      burst(6, 20, 20);
      idle(20);
      rd(ucte_pkg::OFS_COUNT, 32'h1, 32'hffff);
      check(32'(irq_n - i0), 32'h2);
      rd(ucte_pkg::OFS_CAPTURE, 32'h0, 32'h0);
      check(32'(rdv < 2), 32'h1);
      wr(ucte_pkg::OFS_CTRL, 32'h08, 4'h3);
    end
    // Short pulses: dropped by the filter, counted with it bypassed
    wr(ucte_pkg::OFS_CTRL, 32'h2c, 4'h3);
    burst(3, 3, 20);
    rd(ucte_pkg::OFS_COUNT, 32'h0, 32'hffff);
    wr(ucte_pkg::OFS_CTRL, 32'h08, 4'h3);
    wr(ucte_pkg::OFS_CTRL, 32'h22c, 4'h3);
    burst(3, 3, 20);
    rd(ucte_pkg::OFS_COUNT, 32'h3, 32'hffff);
    test_end("event");
    test_done();
  end
endmodule
